/* rtl/pri_host.sv */
// Bus master that writes and reads single registers of the power device.
`timescale 1ns/1ps
`default_nettype none
module pri_host (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  input  wire logic       REQ,
  input  wire logic       REQ_RD,
  input  wire logic [7:0] REQ_REG,
  input  wire logic [7:0] REQ_WDATA,
  output var  logic       READY,
  output var  logic       DONE,
  output var  logic       NACK,
  output var  logic [7:0] RDATA,
  input  wire logic       SCL_I,
  output var  logic       SCL_O,
  output var  logic       SCL_OE,
  input  wire logic       SDA_I,
  output var  logic       SDA_O,
  output var  logic       SDA_OE
);
  import pri_pkg::*;

  pri_regs_t  q;
  pri_regs_t  d;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       step;
  logic       enter;
  logic       stall;
  logic       rx;

  ////////////////////////////////////////////////////////////////////////////
  pri_sync #(.W(2)) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .din   ({SCL_I, SDA_I}),
    .dout  (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d     = q;
    d.done = 1'b0;
    step  = 1'b0;
    enter = 1'b0;
    // A slave holding SCL low while we release it stretches the low phase.
    stall = q.qtr[1] && !q.scl_oe && !scl_s;
    rx    = (q.byte_idx == BYTE_RX);
    if (q.st == ST_IDLE) begin
      if (REQ) begin
        d.st       = ST_START;
        d.qtr      = 2'h0;
        d.cnt      = 5'h0;
        d.bitn     = 4'h0;
        d.byte_idx = BYTE_ADDR;
        d.shreg    = ADDR_WR_BYTE;
        d.rd       = REQ_RD;
        d.regad    = REQ_REG;
        d.wdata    = REQ_WDATA;
        d.nack     = 1'b0;
        enter      = 1'b1;
      end
    end else if (!stall) begin
      if (q.cnt == QTR_LAST) begin
        d.cnt = 5'h0;
        step  = 1'b1;
      end else begin
        d.cnt = q.cnt + 5'h1;
      end
    end

    if (step) begin
      enter = 1'b1;
      d.qtr = q.qtr + 2'h1;
      if (q.qtr == QTR_LAST_IDX) begin
        unique case (q.st)
          ST_START: begin
            d.st   = ST_BIT;
            d.bitn = 4'h0;
          end
          ST_STOP: begin
            d.st   = ST_IDLE;
            d.done = 1'b1;
          end
          ST_BIT: begin
            if (q.bitn != ACK_SLOT) begin
              // One shifter serves both directions: out of the top, in at the bottom.
              d.shreg = {q.shreg[6:0], sda_s};
              d.bitn  = q.bitn + 4'h1;
            end else begin
              d.bitn = 4'h0;
              if (rx) begin
                d.rdata = q.shreg;
                d.st    = ST_STOP;
              end else if (sda_s) begin
                d.nack = 1'b1;
                d.st   = ST_STOP;
              end else begin
                unique case (q.byte_idx)
                  BYTE_ADDR: begin
                    d.byte_idx = BYTE_REG;
                    d.shreg    = q.regad;
                  end
                  BYTE_REG: begin
                    d.byte_idx = BYTE_THIRD;
                    if (q.rd) begin
                      d.st    = ST_START;
                      d.shreg = ADDR_RD_BYTE;
                    end else begin
                      d.shreg = q.wdata;
                    end
                  end
                  default: begin
                    if (q.rd) begin
                      d.byte_idx = BYTE_RX;
                      d.shreg    = 8'hff;
                    end else begin
                      d.st = ST_STOP;
                    end
                  end
                endcase
              end
            end
          end
          default: d.st = ST_IDLE;
        endcase
      end
    end

    // Line actions on entry to each quarter of the current state.
    if (enter) begin
      unique case (d.st)
        ST_START: begin
          unique case (d.qtr)
            2'h0: d.scl_oe = 1'b1;
            2'h1: d.sda_oe = 1'b0;
            2'h2: d.scl_oe = 1'b0;
            2'h3: d.sda_oe = 1'b1;
          endcase
        end
        ST_BIT: begin
          unique case (d.qtr)
            2'h0: d.scl_oe = 1'b1;
            // SDA moves only a quarter after SCL fell, never while it is high.
            2'h1: d.sda_oe = (d.bitn != ACK_SLOT) && (d.byte_idx != BYTE_RX)
                             && !d.shreg[7];
            2'h2: d.scl_oe = 1'b0;
            2'h3: d.scl_oe = 1'b0;
          endcase
        end
        ST_STOP: begin
          unique case (d.qtr)
            2'h0: d.scl_oe = 1'b1;
            2'h1: d.sda_oe = 1'b1;
            2'h2: d.scl_oe = 1'b0;
            2'h3: d.sda_oe = 1'b0;
          endcase
        end
        default: begin
          d.scl_oe = 1'b0;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;
    end else if (CE) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign READY  = (q.st == ST_IDLE);
  assign DONE   = q.done;
  assign NACK   = q.nack;
  assign RDATA  = q.rdata;
  assign SCL_O  = 1'b0;
  assign SDA_O  = 1'b0;
  assign SCL_OE = q.scl_oe;
  assign SDA_OE = q.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Helper: cycles since SCL drive last changed, saturating.
  // It freezes with CE, so a paused link is judged in running cycles only.
  localparam int HALF_MIN = 30;
  logic [7:0] edge_cnt_q;
  logic       scl_prev_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      edge_cnt_q <= 8'h00;
      scl_prev_q <= 1'b0;
    end else if (CE) begin
      scl_prev_q <= q.scl_oe;
      if (q.scl_oe != scl_prev_q) begin
        edge_cnt_q <= 8'h00;
      end else if (edge_cnt_q != 8'hff) begin
        edge_cnt_q <= edge_cnt_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_idle_released: assert property (
    q.st == ST_IDLE |-> !q.scl_oe && !q.sda_oe)
    else $error("bus not released while idle");
  a_sda_steady_high: assert property (
    ($changed(q.sda_oe) && q.st == ST_BIT) |-> (q.scl_oe && $past(q.scl_oe)))
    else $error("SDA moved while SCL high inside a bit");
  a_start_only: assert property (
    ($rose(q.sda_oe) && !q.scl_oe) |-> q.st == ST_START)
    else $error("SDA fell with SCL high outside START");
  a_addr_first: assert property (
    ($past(q.st) == ST_START && q.st == ST_BIT && q.byte_idx == BYTE_ADDR)
      |-> q.shreg == ADDR_WR_BYTE)
    else $error("first byte after START is not the write address");
  a_reg_second: assert property (
    ($changed(q.byte_idx) && q.byte_idx == BYTE_REG) |-> q.shreg == q.regad)
    else $error("register address not sent second");
  a_read_dir_bit: assert property (
    ($past(q.st) == ST_START && q.st == ST_BIT && q.byte_idx == BYTE_THIRD)
      |-> q.rd && q.shreg == ADDR_RD_BYTE)
    else $error("repeated START not followed by read address");
  a_bit_on_rise: assert property (
    (q.st == ST_BIT && $changed(q.bitn)) |-> !$past(q.scl_oe))
    else $error("bit counted while SCL low");
  a_scl_half_min: assert property (
    (q.scl_oe != scl_prev_q && q.st != ST_IDLE && $past(q.st) != ST_IDLE)
      |-> edge_cnt_q >= HALF_MIN)
    else $error("SCL half period too short");
  a_slave_ack_free: assert property (
    (q.st == ST_BIT && q.bitn == ACK_SLOT && q.qtr != 2'h0) |-> !q.sda_oe)
    else $error("master drove SDA in slave ACK slot");
  a_read_nack: assert property (
    (q.st == ST_BIT && q.byte_idx == BYTE_RX && q.qtr != 2'h0) |-> !q.sda_oe)
    else $error("master drove SDA during single read byte");
  a_done_after_stop: assert property (
    DONE |-> ($past(q.st) == ST_STOP && q.st == ST_IDLE))
    else $error("DONE without a STOP");
  a_nack_stops: assert property (
    $rose(q.nack) |-> q.st == ST_STOP ##1 q.st == ST_STOP)
    else $error("NACK not followed by STOP");

  // Handshake side: DONE is a single pulse and NACK clears only on a new request.
  a_done_pulse: assert property (
    (DONE && CE) |=> !DONE)
    else $error("DONE stood longer than one cycle");
  a_nack_clear: assert property (
    $fell(q.nack) |-> (q.st == ST_START && $past(q.st) == ST_IDLE))
    else $error("NACK cleared outside a new request");
  a_req_starts: assert property (
    (q.st == ST_IDLE && REQ && CE) |=> (q.st == ST_START && q.scl_oe && !READY))
    else $error("accepted request did not begin a START");
  a_rdata_on_rx: assert property (
    $changed(q.rdata) |-> (q.st == ST_STOP && q.byte_idx == BYTE_RX))
    else $error("read data changed outside the read byte");

  // Line timing: a frozen or stretched quarter never shortens an SCL phase.
  a_qtr_bound: assert property (
    q.cnt <= QTR_LAST)
    else $error("quarter timer ran past its end");
  a_stretch_holds: assert property (
    (stall && CE) |=> $stable(q.cnt))
    else $error("quarter timer ran while SCL was held low");
  a_ce_freeze: assert property (
    !CE |=> $stable(q))
    else $error("state moved while the clock enable was low");
  a_sample_scl_high: assert property (
    (step && q.qtr == QTR_LAST_IDX && q.st == ST_BIT) |-> (!q.scl_oe && scl_s))
    else $error("bit sampled while SCL was low");

  // Framing: bits stay within nine slots, and START and STOP sit on a high SCL.
  a_nine_slots: assert property (
    q.bitn <= ACK_SLOT)
    else $error("bit counter passed the acknowledge slot");
  a_wr_data_third: assert property (
    ($changed(q.byte_idx) && q.byte_idx == BYTE_THIRD && !q.rd) |-> q.shreg == q.wdata)
    else $error("write data not sent after the register address");
  a_shift_out: assert property (
    (q.st == ST_BIT && q.qtr == 2'h2 && q.bitn != ACK_SLOT && q.byte_idx != BYTE_RX)
      |-> q.sda_oe == !q.shreg[7])
    else $error("driven bit differs from the shifter top bit");
  a_start_scl_high: assert property (
    ($rose(q.sda_oe) && q.st == ST_START) |-> (!q.scl_oe && scl_s))
    else $error("START formed while SCL was low");
  a_stop_release: assert property (
    ($fell(q.sda_oe) && q.st == ST_STOP) |-> !q.scl_oe)
    else $error("SDA released with SCL low while closing");

endmodule : pri_host
`default_nettype wire

/* include/pri_pkg.sv */
// Constants and types for the host-side two-wire register port master.
package pri_pkg;

  localparam logic [6:0] SLAVE_ADDR    = 7'h28;
  localparam logic [7:0] ADDR_WR_BYTE  = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] ADDR_RD_BYTE  = {SLAVE_ADDR, 1'b1};

  localparam int         CLK_PERIOD_NS = 40;
  localparam int         SCL_MAX_KHZ   = 400;
  localparam int         SCL_MIN_PER_NS = 1000000 / SCL_MAX_KHZ;
  // A bit cell is four equal quarters; a least time rounds up.
  localparam int         QTR_CYC_INT   = (SCL_MIN_PER_NS + 4 * CLK_PERIOD_NS - 1)
                                         / (4 * CLK_PERIOD_NS);
  localparam logic [4:0] QTR_LAST      = 5'(QTR_CYC_INT - 1);

  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [1:0] BYTE_ADDR     = 2'h0;
  localparam logic [1:0] BYTE_REG      = 2'h1;
  localparam logic [1:0] BYTE_THIRD    = 2'h2;
  localparam logic [1:0] BYTE_RX       = 2'h3;
  localparam logic [1:0] QTR_SDA       = 2'h1;
  localparam logic [1:0] QTR_LAST_IDX  = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BIT   = 2'b11,
    ST_STOP  = 2'b10
  } pri_state_t;

  typedef struct packed {
    pri_state_t  st;
    logic [1:0]  qtr;
    logic [4:0]  cnt;
    logic [3:0]  bitn;
    logic [1:0]  byte_idx;
    logic [7:0]  shreg;
    logic        rd;
    logic [7:0]  regad;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        done;
    logic        nack;
    logic        scl_oe;
    logic        sda_oe;
  } pri_regs_t;

endpackage : pri_pkg

/* rtl/pri_sync.sv */
// Two-stage synchroniser for pin levels entering the CLK domain.
`timescale 1ns/1ps
`default_nettype none
module pri_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  // Idle bus reads high, so both stages reset to one.
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else if (ce) begin
        meta_q <= din[i];
        sync_q <= meta_q;
      end
    end
    assign dout[i] = sync_q;
  end

endmodule : pri_sync
`default_nettype wire

/* test/pri_dev_model.sv */
// Behavioural register device standing on the far end of the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module pri_dev_model #(
  parameter logic [7:0] NREG = 8'h20
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] my_addr,
  input  wire logic       slow,
  output var  logic       scl_oe,
  output var  logic       sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] sh, ptr;
  logic [3:0] bitn;
  logic [1:0] nbyte;
  logic       act, fresh, rd, tx, mack, ok;
  int         nstart, nstop;
  initial begin
    {scl_oe, sda_oe, act, fresh, tx} = 5'h00;
    nstart = 0;
    nstop = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  ////////////////////////////////////////
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      nstart++;
      {act, fresh, tx, bitn, nbyte} = {3'b110, 6'h00};
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      nstop++;
      act = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (act && !tx && bitn < 4'h8) sh = {sh[6:0], sda};
    if (act && bitn == 4'h8) mack = !sda;
  end
  // Slow mode stretches every low phase, so the host must wait on the wire.
  always @(negedge scl) begin
    if (slow) begin
      scl_oe = 1'b1;
      #3000;
      scl_oe = 1'b0;
    end
  end
  // The first falling clock after a START belongs to the START, not to a bit.
  always @(negedge scl) begin
    if (!act || fresh) fresh = 1'b0;
    else if (bitn == 4'h7) begin
      bitn = 4'h8;
      sda_oe = 1'b0;
      if (!tx) begin
        case (nbyte)
          2'h0: begin
            rd = sh[0];
            ok = (sh[7:1] == my_addr);
          end
          2'h1: begin
            ptr = sh;
            ok = (sh < NREG);
          end
          default: begin
            mem[ptr] = sh;
            ok = 1'b1;
            if (ptr != 8'h00) ptr = ptr + 8'h01;
          end
        endcase
        sda_oe = ok;
        if (!ok) act = 1'b0;
      end
    end else if (bitn == 4'h8) begin
      bitn = 4'h0;
      sda_oe = 1'b0;
      if (nbyte != 2'h2) nbyte = nbyte + 2'h1;
      if (tx && !mack) act = 1'b0;
      else if (rd) begin
        if (tx) ptr = ptr + 8'h01;
        tx = 1'b1;
        sh = mem[ptr];
        sda_oe = !sh[7];
      end
    end else begin
      bitn = bitn + 4'h1;
      if (tx) sda_oe = !sh[3'(4'h7 - bitn)];
    end
  end
endmodule : pri_dev_model
`default_nettype wire

/* test/test_pmic_i2c_register_port.sv */
// Bench for the host port: single-register accesses against the device model.
`timescale 1ns/1ps
`default_nettype none
module test_pmic_i2c_register_port;
  import pri_pkg::*;
  logic       clk, rstn, ce, req, req_rd, ready, done, nack, scl_oe, sda_oe;
  logic       slow, d_scl_oe, d_sda_oe, scl_o, sda_o;
  logic [7:0] req_reg, req_wdata, rdata;
  logic [6:0] dev_addr;
  int         bad_count, checks_done, fast_cnt, dev_drv, s0, p0;
  realtime    t_rise;
  // Both lines have pull-ups: low while either party pulls.
  wire        scl = !scl_oe && !d_scl_oe;
  wire        sda = !sda_oe && !d_sda_oe;
  pri_host dut_u (.CLK(clk), .RSTN(rstn), .CE(ce), .REQ(req), .REQ_RD(req_rd),
    .REQ_REG(req_reg), .REQ_WDATA(req_wdata), .READY(ready), .DONE(done), .NACK(nack),
    .RDATA(rdata), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe));
  pri_dev_model dev_u (.scl(scl), .sda(sda), .my_addr(dev_addr), .slow(slow),
    .scl_oe(d_scl_oe), .sda_oe(d_sda_oe));
  always #20 clk = !clk;
  always @(posedge d_sda_oe) dev_drv++;
  always @(posedge scl) begin
    if (t_rise > 0 && $realtime - t_rise < 2500.0) fast_cnt++;
    t_rise = $realtime;
  end
  ////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic xfer(input logic rd, input logic [7:0] ra, input logic [7:0] wd, input int ns);
    int n;
    s0 = dev_u.nstart;
    p0 = dev_u.nstop;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    req <= 1'b1;
    req_rd <= rd;
    req_reg <= ra;
    req_wdata <= wd;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    chk_bit(ready, 1'b0, "busy");
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    chk_bit(done, 1'b1, "done");
    chk_bit(ready, 1'b1, "ready");
    chk_bit(scl_o | sda_o, 1'b0, "open drain");
    chk_bit(scl & sda, 1'b1, "idle");
    chk_byte(8'(dev_u.nstart - s0), 8'(ns), "starts");
    chk_byte(8'(dev_u.nstop - p0), 8'h01, "stops");
  endtask : xfer
  ////////////////////////////////////////
  task automatic t_write;
    xfer(1'b0, 8'h05, 8'ha5, 1);
    chk_bit(nack, 1'b0, "write nack");
    chk_byte(dev_u.mem[5], 8'ha5, "write data");
  endtask : t_write
  task automatic t_read;
    // A pause of the clock enable inside the access must only lengthen it.
    fork
      xfer(1'b1, 8'h05, 8'h00, 2);
      begin
        repeat (600) @(posedge clk);
        ce <= 1'b0;
        repeat (90) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk_bit(nack, 1'b0, "read nack");
    chk_byte(rdata, 8'ha5, "read data");
  endtask : t_read
  task automatic t_bad_reg;
    xfer(1'b0, 8'h20, 8'h3c, 1);
    chk_bit(nack, 1'b1, "bad reg nack");
    chk_byte(dev_u.mem[8'h20], 8'h00, "bad reg data");
  endtask : t_bad_reg
  task automatic t_other_addr;
    int d0;
    d0 = dev_drv;
    dev_addr = 7'h29;
    xfer(1'b0, 8'h05, 8'h11, 1);
    chk_bit(nack, 1'b1, "addr nack");
    chk_byte(8'(dev_drv - d0), 8'h00, "silent");
    chk_byte(dev_u.mem[5], 8'ha5, "addr data");
    dev_addr = SLAVE_ADDR;
  endtask : t_other_addr
  task automatic t_slow;
    slow = 1'b1;
    xfer(1'b0, 8'h1f, 8'h5a, 1);
    xfer(1'b1, 8'h1f, 8'h00, 2);
    chk_byte(rdata, 8'h5a, "slow data");
    chk_byte(8'(fast_cnt), 8'h00, "scl rate");
    slow = 1'b0;
  endtask : t_slow
  task automatic results;
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////
  initial begin
    {clk, rstn, req, req_rd, slow} = 5'h00;
    ce = 1'b1;
    req_reg = 8'h00;
    req_wdata = 8'h00;
    dev_addr = SLAVE_ADDR;
    {bad_count, checks_done, fast_cnt, dev_drv} = {4{32'h0}};
    t_rise = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_write;
    t_read;
    t_bad_reg;
    t_other_addr;
    t_slow;
    results;
  end
  initial begin
    #1600000;
    bad_count++;
    results;
  end
endmodule : test_pmic_i2c_register_port
`default_nettype wire
